// ### rtl/rfh_regs.svh
// Register offsets, field positions, reset values and levels of the reader FIFO host port.
`ifndef RFH_REGS_SVH
`define RFH_REGS_SVH

`define RFH_ADR_IRQ 5'h0c
`define RFH_ADR_FLAGS 5'h1c
`define RFH_ADR_TXU 5'h1d
`define RFH_ADR_TXL 5'h1e
`define RFH_ADR_FIFO 5'h1f
`define RFH_CMD_FIFO_RESET 5'h0f

`define RFH_W_CMD 7
`define RFH_W_RD 6
`define RFH_W_CONT 5

`define RFH_IRQ_TX 7
`define RFH_IRQ_SOF 6
`define RFH_IRQ_RXHI 5
`define RFH_IRQ_CRC 3
`define RFH_IRQ_FRAME 2

`define RFH_FLG_OVF 4
`define RFH_FLG_LOW 5
`define RFH_FLG_HIGH 6

`define RFH_TXU_RST 8'h00
`define RFH_TXL_RST 8'h00
`define RFH_IRQ_RST 8'h00

`define RFH_FIFO_LAST 4'hb
`define RFH_FIFO_FULL 4'hc
`define RFH_HIGH_LEVEL 4'h9
`define RFH_RX_HIGH_COUNT 4'h8
`define RFH_TX_LOW_COUNT 4'h4
`define RFH_TX_LOW_LEFT 13'h0003
`define RFH_TX_LONG_MIN 13'h0005
`define RFH_FULL_BITS 4'h8

`endif

// ### rtl/rfh_pkg.sv
// Types shared by the reader FIFO host port.
package rfh_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_END} rfh_tx_state_t;

  typedef enum logic [1:0] {HP_ADDR, HP_DATA, HP_DONE} rfh_port_phase_t;

endpackage

// ### rtl/rfh_sync.sv
// Two-flop synchroniser for one level or toggle signal.
`timescale 1ns/10ps
module rfh_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### rtl/rfh_fifo_port.sv
// Reader FIFO, transmit length counters, level flags and parallel host port.
//
// Overview of operation
// - Twelve-byte FIFO at register 0x1F, locations 0 to 11 used circularly.
// - Command 0x0F empties the FIFO and its byte counter.
// - Register 0x1C bits 3:0 report stored bytes minus one.
// - Twelve-bit transmit byte count over 0x1D and 0x1E, partial bits in 0x1E[3:0].
// - End-of-frame follows the counted whole bytes and partial-byte bits.
// - Bit 4 of 0x1C flags FIFO writes arriving too soon.
// - Bit 5 of 0x1C flags three bytes left to transmit.
// - Bit 6 of 0x1C flags nine or more bytes held.
// - Interrupt when a transmit pop in a frame of five or more drops occupancy to three or a received byte lifts it to nine.
// - Transmission starts by itself on the first FIFO byte written.
// - Data line 7 rising while host clock high starts and resets the port.
// - After a start the host sends the address word, then data.
// - Data line 7 falling while host clock high is a simple stop.
// - Line 7 rising then falling while clock low is a continuous stop.
// - Start of a received frame sets bit 6 of register 0x0C.
// - Received frames of eight bytes or fewer interrupt only at the end.
// - Longer received frames interrupt at the ninth byte, bit 5, and at end.
// - Failed reception sets the framing or CRC error bit in 0x0C.
// - 0x1D holds upper and middle count nibbles, 0x1E lower nibble and bits.
// - Transmit start sets bit 7; frames of five or more also interrupt early.
// - First word: bit 7 command, bit 6 read, bit 5 continuous, 4:0 code.
// - Continuous mode steps the address per data byte, except at 0x1F; single mode takes one.
`timescale 1ns/10ps
`include "rfh_regs.svh"
module rfh_fifo_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic DATA_CLK,
  input wire logic [7:0] IO_IN,
  output logic [7:0] IO_OUT,
  output logic IO_OE,
  output logic IRQ,
  input wire logic TX_TAKE,
  output logic [7:0] TX_BYTE,
  output logic [3:0] TX_BITS,
  output logic TX_STROBE,
  output logic TX_EOF,
  input wire logic RX_SOF,
  input wire logic RX_STROBE,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_DONE,
  input wire logic RX_FRAME_ERR,
  input wire logic RX_CRC_ERR
);

  // Link-domain state.
  logic d7_p;
  logic [7:0] w_cap;
  logic rise_tog;
  logic rise_seen;
  logic cstop_tog;
  logic in_frame;
  logic first;
  logic rd_mode;
  logic [7:0] word_data;
  logic word_first;
  logic word_tog;
  logic rd_l;
  logic rd_seen;
  logic cstop_lseen;

  // Core-domain state.
  logic word_s;
  logic cstop_s;
  logic word_seen;
  logic cstop_seen;
  logic [7:0] mem [0:11];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [3:0] count;
  logic [7:0] tx_upper;
  logic [7:0] tx_lower;
  logic [7:0] irq_cause;
  logic ovf_flag;
  logic rx_active;
  logic [12:0] tx_left;
  logic tx_long;
  rfh_pkg::rfh_tx_state_t tx_state;
  rfh_pkg::rfh_port_phase_t phase;
  logic [4:0] cur_addr;
  logic cur_rd;
  logic cur_cont;
  logic prep;
  logic [4:0] prep_addr;
  logic [7:0] rd_word;
  logic rd_tog;

  // Host port samples bus and line 7 on the rising host clock edge.
  always_ff @(posedge DATA_CLK or posedge RST) begin
    if (RST) begin
      d7_p <= 1'b0;
      w_cap <= 8'h00;
      rise_seen <= 1'b0;
    end else begin
      d7_p <= IO_IN[7];
      w_cap <= IO_IN;
      rise_seen <= rise_tog;
    end
  end

  // Marks each rise of line 7 that happens while the host clock is low.
  always_ff @(posedge IO_IN[7] or posedge RST) begin
    if (RST) begin
      rise_tog <= 1'b0;
    end else if (!DATA_CLK) begin
      rise_tog <= ~rise_tog;
    end
  end

  // A fall of line 7 in the same low phase as such a rise ends the sequence.
  always_ff @(negedge IO_IN[7] or posedge RST) begin
    if (RST) begin
      cstop_tog <= 1'b0;
    end else if (!DATA_CLK && rise_tog != rise_seen) begin
      cstop_tog <= ~cstop_tog;
    end
  end

  // Framing on the falling host clock edge: start, stop and word hand-off.
  always_ff @(negedge DATA_CLK or posedge RST) begin
    if (RST) begin
      in_frame <= 1'b0;
      first <= 1'b0;
      rd_mode <= 1'b0;
      IO_OE <= 1'b0;
      word_data <= 8'h00;
      word_first <= 1'b0;
      word_tog <= 1'b0;
      cstop_lseen <= 1'b0;
    end else if (!d7_p && IO_IN[7]) begin
      in_frame <= 1'b1;
      first <= 1'b1;
      rd_mode <= 1'b0;
      IO_OE <= 1'b0;
      cstop_lseen <= cstop_tog; // The host clock stands still during a stop, so this is settled.
    end else if (d7_p && !IO_IN[7] && in_frame) begin
      in_frame <= 1'b0;
      IO_OE <= 1'b0;
    end else if (cstop_tog != cstop_lseen) begin
      cstop_lseen <= cstop_tog;
      in_frame <= 1'b0;
      IO_OE <= 1'b0;
    end else if (in_frame) begin
      word_data <= w_cap;
      word_first <= first;
      word_tog <= ~word_tog;
      if (first) begin
        rd_mode <= ~w_cap[`RFH_W_CMD] & w_cap[`RFH_W_RD];
        IO_OE <= ~w_cap[`RFH_W_CMD] & w_cap[`RFH_W_RD];
        first <= 1'b0;
      end
    end
  end

  // Read data from the core is driven while the host clock is low.
  always_ff @(negedge DATA_CLK or posedge RST) begin
    if (RST) begin
      IO_OUT <= 8'h00;
      rd_seen <= 1'b0;
    end else if (rd_l != rd_seen) begin
      IO_OUT <= rd_word;
      rd_seen <= rd_l;
    end
  end

  // Crossings between the host clock and the core clock.
  rfh_sync u_word (.clk(CLK), .rst(RST), .d(word_tog), .q(word_s));
  rfh_sync u_cstop (.clk(CLK), .rst(RST), .d(cstop_tog), .q(cstop_s));
  rfh_sync u_rd (.clk(DATA_CLK), .rst(RST), .d(rd_tog), .q(rd_l));

  // Decoded host and air events of the current core cycle.
  logic evt;
  logic is_cmd;
  logic host_wr;
  logic host_rd;
  logic fifo_clr;
  logic host_push;
  logic host_pop;
  logic host_ovf;
  logic rx_push;
  logic tx_pop;
  logic push;
  logic pop;
  logic irq_clear;
  logic tx_start;
  logic [12:0] tx_total;
  logic [7:0] irq_set;
  logic irq_event;
  logic [4:0] step_addr;

  assign evt = word_s != word_seen;
  assign is_cmd = evt & word_first & word_data[`RFH_W_CMD];
  assign host_wr = evt & !word_first & phase == rfh_pkg::HP_DATA & !cur_rd;
  assign host_rd = evt & !word_first & phase == rfh_pkg::HP_DATA & cur_rd;
  assign fifo_clr = is_cmd & word_data[4:0] == `RFH_CMD_FIFO_RESET;
  assign host_push = host_wr & cur_addr == `RFH_ADR_FIFO & count != `RFH_FIFO_FULL;
  assign host_ovf = host_wr & cur_addr == `RFH_ADR_FIFO & count == `RFH_FIFO_FULL;
  assign host_pop = host_rd & cur_addr == `RFH_ADR_FIFO & count != 4'h0;
  assign irq_clear = host_rd & cur_addr == `RFH_ADR_IRQ;
  assign rx_push = RX_STROBE & !host_push & count != `RFH_FIFO_FULL;
  assign tx_pop = tx_state == rfh_pkg::TX_SEND & TX_TAKE & count != 4'h0 & !host_pop;
  assign push = host_push | rx_push;
  assign pop = host_pop | tx_pop;
  assign tx_total = {1'b0, tx_upper, tx_lower[7:4]} + {12'h000, |tx_lower[3:0]};
  assign tx_start = tx_state == rfh_pkg::TX_IDLE & host_push & tx_total != 13'h0000;
  assign step_addr = (cur_addr == `RFH_ADR_FIFO) ? cur_addr : cur_addr + 5'h01;

  // Interrupt causes raised this cycle.
  always_comb begin
    irq_set = 8'h00;
    irq_event = 1'b0;
    if (tx_start) begin
      irq_set[`RFH_IRQ_TX] = 1'b1;
    end
    if (tx_pop && tx_long && count == `RFH_TX_LOW_COUNT && tx_left > `RFH_TX_LOW_LEFT) begin
      irq_event = 1'b1;
    end
    if (tx_state == rfh_pkg::TX_END && TX_TAKE) begin
      irq_event = 1'b1;
    end
    if (RX_SOF) begin
      irq_set[`RFH_IRQ_SOF] = 1'b1;
    end
    if (rx_push && rx_active && count == `RFH_RX_HIGH_COUNT) begin
      irq_set[`RFH_IRQ_RXHI] = 1'b1;
      irq_event = 1'b1;
    end
    if (RX_DONE && rx_active) begin
      irq_event = 1'b1;
      irq_set[`RFH_IRQ_FRAME] = RX_FRAME_ERR;
      irq_set[`RFH_IRQ_CRC] = RX_CRC_ERR;
    end
  end

  // Acknowledge of host words and edge detection of the continuous-stop toggle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      word_seen <= 1'b0;
      cstop_seen <= 1'b0;
    end else begin
      word_seen <= word_s;
      cstop_seen <= cstop_s;
    end
  end

  // Address word decode and address stepping across data words.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase <= rfh_pkg::HP_ADDR;
      cur_addr <= 5'h00;
      cur_rd <= 1'b0;
      cur_cont <= 1'b0;
      prep <= 1'b0;
      prep_addr <= 5'h00;
    end else begin
      prep <= 1'b0;
      if (cstop_s != cstop_seen) begin
        phase <= rfh_pkg::HP_DONE;
      end else if (evt && word_first) begin
        if (word_data[`RFH_W_CMD]) begin
          phase <= rfh_pkg::HP_DONE;
        end else begin
          phase <= rfh_pkg::HP_DATA;
          cur_addr <= word_data[4:0];
          cur_rd <= word_data[`RFH_W_RD];
          cur_cont <= word_data[`RFH_W_CONT];
          prep <= word_data[`RFH_W_RD];
          prep_addr <= word_data[4:0];
        end
      end else if (host_wr || host_rd) begin
        if (cur_cont) begin
          cur_addr <= step_addr;
          prep <= cur_rd;
          prep_addr <= step_addr;
        end else begin
          phase <= rfh_pkg::HP_DONE;
        end
      end
    end
  end

  // Read data is taken one cycle after the access so a pop has landed.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_word <= 8'h00;
      rd_tog <= 1'b0;
    end else if (prep) begin
      rd_tog <= ~rd_tog;
      case (prep_addr)
        `RFH_ADR_IRQ: rd_word <= irq_cause;
        `RFH_ADR_FLAGS: rd_word <= {1'b0, count >= `RFH_HIGH_LEVEL,
          tx_state == rfh_pkg::TX_SEND && tx_left == `RFH_TX_LOW_LEFT,
          ovf_flag, count - 4'h1};
        `RFH_ADR_TXU: rd_word <= tx_upper;
        `RFH_ADR_TXL: rd_word <= tx_lower;
        `RFH_ADR_FIFO: rd_word <= mem[rd_ptr];
        default: rd_word <= 8'h00;
      endcase
    end
  end

  // Transmit length registers written by the host.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_upper <= `RFH_TXU_RST;
      tx_lower <= `RFH_TXL_RST;
    end else if (host_wr) begin
      if (cur_addr == `RFH_ADR_TXU) begin
        tx_upper <= word_data;
      end
      if (cur_addr == `RFH_ADR_TXL) begin
        tx_lower <= word_data;
      end
    end
  end

  // Circular FIFO storage, pointers and occupancy.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 4'h0;
    end else if (fifo_clr) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 4'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= host_push ? word_data : RX_BYTE;
        wr_ptr <= (wr_ptr == `RFH_FIFO_LAST) ? 4'h0 : wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == `RFH_FIFO_LAST) ? 4'h0 : rd_ptr + 4'h1;
      end
      if (push && !pop) begin
        count <= count + 4'h1;
      end else if (pop && !push) begin
        count <= count - 4'h1;
      end
    end
  end

  // Overflow flag; a new overflow wins over a FIFO reset in the same cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovf_flag <= 1'b0;
    end else begin
      ovf_flag <= (ovf_flag & !fifo_clr) | host_ovf | (RX_STROBE & !rx_push);
    end
  end

  // Transmit sequencer feeding bytes and the end-of-frame to the framer.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_state <= rfh_pkg::TX_IDLE;
      tx_left <= 13'h0000;
      tx_long <= 1'b0;
      TX_BYTE <= 8'h00;
      TX_BITS <= 4'h0;
      TX_STROBE <= 1'b0;
      TX_EOF <= 1'b0;
    end else begin
      TX_STROBE <= 1'b0;
      TX_EOF <= 1'b0;
      case (tx_state)
        rfh_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state <= rfh_pkg::TX_SEND;
            tx_left <= tx_total;
            tx_long <= tx_total >= `RFH_TX_LONG_MIN;
          end
        end
        rfh_pkg::TX_SEND: begin
          if (fifo_clr) begin
            tx_state <= rfh_pkg::TX_IDLE;
          end else if (tx_pop) begin
            TX_BYTE <= mem[rd_ptr];
            TX_STROBE <= 1'b1;
            TX_BITS <= (tx_left == 13'h0001 && tx_lower[3:0] != 4'h0) ?
              tx_lower[3:0] : `RFH_FULL_BITS;
            tx_left <= tx_left - 13'h0001;
            if (tx_left == 13'h0001) begin
              tx_state <= rfh_pkg::TX_END;
            end
          end
        end
        rfh_pkg::TX_END: begin
          if (TX_TAKE) begin
            TX_EOF <= 1'b1;
            tx_state <= rfh_pkg::TX_IDLE;
          end
        end
        default: tx_state <= rfh_pkg::TX_IDLE;
      endcase
    end
  end

  // Receive activity window between start of frame and end of reception.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_active <= 1'b0;
    end else if (RX_SOF) begin
      rx_active <= 1'b1;
    end else if (RX_DONE) begin
      rx_active <= 1'b0;
    end
  end

  // Interrupt causes and request; reading 0x0C clears, new events win.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_cause <= `RFH_IRQ_RST;
      IRQ <= 1'b0;
    end else begin
      irq_cause <= (irq_clear ? 8'h00 : irq_cause) | irq_set;
      IRQ <= (IRQ & !irq_clear) | irq_event;
    end
  end

endmodule

// ### bench/rfh_fifo_port_assertions.sv
// Port-level checker for the reader FIFO host port.
`timescale 1ns/10ps
module rfh_fifo_port_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic DATA_CLK,
  input wire logic [7:0] IO_IN,
  input wire logic IO_OE,
  input wire logic IRQ,
  input wire logic TX_TAKE,
  input wire logic [3:0] TX_BITS,
  input wire logic TX_STROBE,
  input wire logic TX_EOF,
  input wire logic RX_SOF,
  input wire logic RX_STROBE
);
  logic [3:0] rx_cnt;
  logic [7:0] seen_word;
  // Counts bytes of the current reception, saturating at fifteen.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_cnt <= 4'h0;
    end else if (RX_SOF) begin
      rx_cnt <= 4'h0;
    end else if (RX_STROBE && rx_cnt != 4'hf) begin
      rx_cnt <= rx_cnt + 4'h1;
    end
  end
  // Holds the word captured at the latest host clock rise.
  always_ff @(posedge DATA_CLK or posedge RST) begin
    if (RST) begin
      seen_word <= 8'h00;
    end else begin
      seen_word <= IO_IN;
    end
  end
  property p_strobe_cause;
    @(posedge CLK) disable iff (RST) TX_STROBE |-> $past(TX_TAKE) && !TX_EOF;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("unit without request");
  property p_eof_cause;
    @(posedge CLK) disable iff (RST) TX_EOF |-> $past(TX_TAKE);
  endproperty
  a_eof_cause: assert property (p_eof_cause) else $error("frame end without request");
  property p_eof_irq;
    @(posedge CLK) disable iff (RST) TX_EOF |-> ##[1:2] IRQ;
  endproperty
  a_eof_irq: assert property (p_eof_irq) else $error("no interrupt at frame end");
  property p_eof_once;
    @(posedge CLK) disable iff (RST) TX_EOF |=> !TX_EOF [*3];
  endproperty
  a_eof_once: assert property (p_eof_once) else $error("frame end repeated");
  property p_bits_range;
    @(posedge CLK) disable iff (RST) TX_STROBE |-> (TX_BITS != 4'h0) && (TX_BITS <= 4'h8);
  endproperty
  a_bits_range: assert property (p_bits_range) else $error("bad unit width");
  property p_rx_ninth;
    @(posedge CLK) disable iff (RST) (RX_STROBE && rx_cnt == 4'h8) |-> ##[1:3] IRQ;
  endproperty
  a_rx_ninth: assert property (p_rx_ninth) else $error("no interrupt at ninth byte");
  property p_read_oe;
    @(posedge CLK) disable iff (RST) $rose(IO_OE) |-> seen_word[7:6] == 2'b01;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("bus driven without read word");
  property p_irq_fall;
    @(posedge CLK) disable iff (RST) $fell(IRQ) |-> IO_OE || $past(IO_OE);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without read");
endmodule
bind rfh_fifo_port rfh_fifo_port_assertions u_chk (.CLK(CLK), .RST(RST), .DATA_CLK(DATA_CLK),
  .IO_IN(IO_IN), .IO_OE(IO_OE), .IRQ(IRQ), .TX_TAKE(TX_TAKE), .TX_BITS(TX_BITS),
  .TX_STROBE(TX_STROBE), .TX_EOF(TX_EOF), .RX_SOF(RX_SOF), .RX_STROBE(RX_STROBE));

// ### bench/rfh_host_model.sv
// Host controller model that drives the parallel port and its data clock.
`timescale 1ns/10ps
module rfh_host_model #(
  parameter int GAP_NS = 450
) (
  output logic data_clk,
  output logic [7:0] io_in,
  input wire logic [7:0] io_out,
  input wire logic io_oe
);
  logic [7:0] bus;
  logic host_drive;
  // The wire follows its driver; a released, undriven bus shows the inverse level.
  always_comb begin
    if (host_drive) io_in = bus;
    else if (io_oe) io_in = io_out;
    else io_in = ~bus;
  end
  // The clock stands still low outside frames and between words.
  initial begin
    data_clk = 1'b0;
    bus = 8'hff;
    host_drive = 1'b1;
  end
  // One host clock cycle; each rise inside a frame captures the bus.
  task automatic pulse();
    #4 data_clk = 1'b1;
    #7.5 data_clk = 1'b0;
    #3.5;
  endtask
  // Start: line 7 rises while the clock is high.
  task automatic start();
    bus[7] = 1'b0;
    #4 data_clk = 1'b1;
    #3.5 bus[7] = 1'b1;
    #4 data_clk = 1'b0;
    #GAP_NS;
  endtask
  // One word, changed only while the clock is low, then a pause.
  task automatic word(input logic [7:0] b);
    bus = b;
    pulse();
    #GAP_NS;
  endtask
  // Simple stop: line 7 falls while the clock is high.
  task automatic simple_stop();
    bus[7] = 1'b1;
    #4 data_clk = 1'b1;
    #3.5 bus[7] = 1'b0;
    #4 data_clk = 1'b0;
    #GAP_NS;
  endtask
  // Continuous stop: line 7 rises and falls while the clock is low.
  task automatic continuous_stop();
    bus[7] = 1'b0;
    #4 bus[7] = 1'b1;
    #4 bus[7] = 1'b0;
    #GAP_NS;
  endtask
  // Single-address read; the bus is released while the device answers.
  task automatic read_reg(input logic [4:0] adr, output logic [7:0] val);
    start();
    word({3'b010, adr});
    host_drive = 1'b0;
    repeat (3) begin
      pulse();
      #GAP_NS;
    end
    val = io_out;
    host_drive = 1'b1;
    simple_stop();
  endtask
  // Direct command word closed by a continuous stop.
  task automatic command(input logic [4:0] code);
    start();
    word({3'b100, code});
    continuous_stop();
  endtask
endmodule

// ### bench/rfh_fifo_port_test.sv
// Self-checking testbench of the reader FIFO host port.
`timescale 1ns/10ps
`include "rfh_regs.svh"
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module rfh_fifo_port_test;
  logic clk = 1'b0, rst = 1'b1, tx_take = 1'b0, rx_sof = 1'b0, rx_strobe = 1'b0;
  logic rx_done = 1'b0, rx_frame_err = 1'b0, rx_crc_err = 1'b0;
  logic [7:0] rx_byte = 8'h00, io_in, io_out, tx_byte;
  logic [3:0] tx_bits;
  logic data_clk, io_oe, irq, tx_strobe, tx_eof;
  int fails = 0, checks_done = 0;
  rfh_fifo_port u_dut (.CLK(clk), .RST(rst), .DATA_CLK(data_clk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .IRQ(irq), .TX_TAKE(tx_take), .TX_BYTE(tx_byte),
    .TX_BITS(tx_bits), .TX_STROBE(tx_strobe), .TX_EOF(tx_eof), .RX_SOF(rx_sof),
    .RX_STROBE(rx_strobe), .RX_BYTE(rx_byte), .RX_DONE(rx_done),
    .RX_FRAME_ERR(rx_frame_err), .RX_CRC_ERR(rx_crc_err));
  rfh_host_model u_host (.data_clk(data_clk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  // Core clock of 50 ns.
  always #25 clk = ~clk;
  // Moves to just after the next rising edge.
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  // Framer request for one unit; the answer stands in the cycle after the request.
  task automatic take(input logic [7:0] b, input logic [3:0] n, input logic last);
    tx_take = 1'b1;
    tick();
    tx_take = 1'b0;
    `CHK(tx_eof, last, "frame end")
    if (!last) `CHK({tx_strobe, tx_byte, tx_bits}, {1'b1, b, n}, "unit")
    tick();
  endtask
  // Empties the FIFO, then writes both lengths and the payload in one stream.
  task automatic load_frame(input logic [7:0] lu, input logic [7:0] ll, input int n);
    u_host.command(`RFH_CMD_FIFO_RESET);
    u_host.start();
    u_host.word(8'h3d);
    u_host.word(lu);
    u_host.word(ll);
    for (int i = 0; i < n; i++) u_host.word(8'ha0 + 8'(i));
    u_host.simple_stop();
  endtask
  // One received byte pushed by the framer.
  task automatic rx_push(input logic [7:0] b);
    rx_byte = b;
    rx_strobe = 1'b1;
    tick();
    rx_strobe = 1'b0;
  endtask
  // Reset values of the registers.
  task automatic test_reset_values();
    logic [7:0] v;
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v, 8'h0f, "empty level flags")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    `CHK(v, `RFH_IRQ_RST, "cause reset")
    u_host.read_reg(`RFH_ADR_TXL, v);
    `CHK(v, `RFH_TXL_RST, "length reset")
    $display("test reset values done");
  endtask
  // Five-byte frame: count, low flag, early and final interrupt, clearing read.
  task automatic test_long_tx();
    logic [7:0] v;
    load_frame(8'h00, 8'h50, 5);
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v, 8'h04, "five held")
    take(8'ha0, 4'h8, 1'b0);
    take(8'ha1, 4'h8, 1'b0);
    `CHK(irq, 1'b1, "early interrupt")
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v, 8'h22, "three left")
    for (int i = 2; i < 5; i++) take(8'ha0 + 8'(i), 4'h8, 1'b0);
    take(8'h00, 4'h0, 1'b1);
    `CHK(irq, 1'b1, "end interrupt")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    `CHK(v, 8'h80, "transmit cause")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    `CHK({v, irq}, 9'h000, "cause cleared")
    $display("test long transmit done");
  endtask
  // One byte plus three bits: short frame interrupts only at its end.
  task automatic test_short_tx();
    logic [7:0] v;
    load_frame(8'h00, 8'h13, 2);
    take(8'ha0, 4'h8, 1'b0);
    `CHK(irq, 1'b0, "quiet short frame")
    take(8'ha1, 4'h3, 1'b0);
    take(8'h00, 4'h0, 1'b1);
    `CHK(irq, 1'b1, "short end interrupt")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    $display("test short transmit done");
  endtask
  // Reception of nine bytes with errors reported at its end.
  task automatic test_rx();
    logic [7:0] v;
    rx_sof = 1'b1;
    tick();
    rx_sof = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rx_push(8'hc0 + 8'(i));
      repeat (2) tick();
      `CHK(irq, i == 8, "receive interrupt")
    end
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v, 8'h48, "nine held")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    `CHK(v, 8'h60, "start and high causes")
    u_host.read_reg(`RFH_ADR_FIFO, v);
    `CHK(v, 8'hc0, "oldest byte first")
    rx_frame_err = 1'b1;
    rx_crc_err = 1'b1;
    rx_done = 1'b1;
    tick();
    rx_done = 1'b0;
    repeat (2) tick();
    `CHK(irq, 1'b1, "done interrupt")
    u_host.read_reg(`RFH_ADR_IRQ, v);
    `CHK(v, 8'h0c, "error causes")
    $display("test receive done");
  endtask
  // Thirteenth byte overflows; the reset command empties the counter.
  task automatic test_overflow();
    logic [7:0] v;
    rx_frame_err = 1'b0;
    rx_crc_err = 1'b0;
    for (int i = 0; i < 6; i++) rx_push(8'hd0 + 8'(i));
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v, 8'h5b, "overflow with twelve held")
    u_host.command(`RFH_CMD_FIFO_RESET);
    u_host.read_reg(`RFH_ADR_FLAGS, v);
    `CHK(v[3:0], 4'hf, "emptied")
    $display("test overflow done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence; one link clock pulse, both edges, falls inside reset.
  initial begin
    #10 u_host.pulse();
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    repeat (2) tick();
    test_reset_values();
    test_long_tx();
    test_short_tx();
    test_rx();
    test_overflow();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of about 54 us.
  initial begin
    #400000;
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
